// ==== rtl/fwl_pkg.sv ====
// Constants, types and states of the write latch and mode command logic
// Functional notes
// [R01] Write permit opcode sets the latch
// [R02] Writes, programs, erases need latch set first
// [R03] Single-byte opcodes run only if select rises
// [R04] Write forbid opcode clears the latch
// [R05] Write forbid ignored while in progress
// [R06] Latch clear refuses program, erase, register writes
// [R07] Volatile steer keeps latch, steers next write
// [R08] Status clear zeroes progress, latch, both errors
// [R09] Status clear needs no permit, works busy
// [R10] Error bits keep the device busy
// [R11] Pattern program needs permit, one data byte
// [R12] Pattern program self-timed, busy, then latch clears
// [R13] Pattern write needs permit, updates immediately
// [R14] Host keeps pattern commands within clock limit
// [R15] Pattern read: one dummy, repeating byte out
// [R16] IO lines ignored during the dummy cycle
// [R17] Enter wide address sets address length bit
// [R18] Exit wide address clears address length bit
// [R19] Reset reloads address length from nonvolatile bit
// [R20] Quad peripheral mode moves nibbles on four lines
// [R21] Permit targets nonvolatile, steer targets volatile
// [R22] Pattern read returns the volatile pattern register
package fwl_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
  localparam logic [7:0] OP_VOLATILE_STEER = 8'h50;
  localparam logic [7:0] OP_STATUS_CLEAR = 8'h30;
  localparam logic [7:0] OP_PATTERN_NV_PROGRAM = 8'h43;
  localparam logic [7:0] OP_PATTERN_VOL_WRITE = 8'h4A;
  localparam logic [7:0] OP_PATTERN_READ = 8'h41;
  localparam logic [7:0] OP_ENTER_WIDE_ADDR = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE_ADDR = 8'hE9;

  // Status and configuration bit positions
  localparam int WIP_POS = 0;
  localparam int WEL_POS = 1;
  localparam int PERR_POS = 5;
  localparam int EERR_POS = 6;
  localparam int ADS_POS = 0;
  localparam int ADS_NV_POS = 1;

  // Reset values
  localparam logic [7:0] PATTERN_NV_RST = 8'h00;
  localparam logic [7:0] PATTERN_VOL_RST = 8'h00;

  // Bit counts on the link
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] DATA_END_BITS = 6'h10;
  localparam logic [5:0] STEP_SINGLE = 6'h01;
  localparam logic [5:0] STEP_QUAD = 6'h04;

  // Self-timed pattern program time
  localparam int CLOCK_MHZ = 100;
  localparam int PROG_TIME_NS = 20000;
  localparam int PROG_CYCLES_INT = (PROG_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [11:0] PROG_CYCLES = PROG_CYCLES_INT[11:0];

  // Link decoder states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_CMD   = 7'b0000010,
    ST_DATA  = 7'b0000100,
    ST_TAIL  = 7'b0001000,
    ST_DUMMY = 7'b0010000,
    ST_READ  = 7'b0100000,
    ST_SKIP  = 7'b1000000
  } fwl_state_t;

  // Status bits seen by the rest of the device
  typedef struct packed {
    logic steerVolatile;
    logic addressLength;
    logic eraseErr;
    logic programErr;
    logic writePermit;
    logic inProgress;
  } fwl_status_t;

  // Pins of the serial link, sampled side
  typedef struct packed {
    logic csN;
    logic sck;
    logic [3:0] io;
  } fwl_pins_t;

  // Pin levels of an idle link; select idles high
  localparam fwl_pins_t PINS_IDLE = '{csN: 1'b1, sck: 1'b0, io: 4'h0};

endpackage : fwl_pkg

// ==== rtl/fwl_sync.sv ====
// Two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
module fwl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // One two-stage chain per bit; first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : gBit
    logic meta_ff; // First stage, may go metastable
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        meta_ff <= 1'b0;
        syncOut[i] <= 1'b0;
      end else begin
        meta_ff <= asyncIn[i];
        syncOut[i] <= meta_ff;
      end
    end
  end

endmodule : fwl_sync

// ==== rtl/fwl_cmd.sv ====
// Serial flash write latch, pattern and address mode command logic
`timescale 1ns/1ps
module fwl_cmd (
  input wire logic clock,
  input wire logic arst_n,
  input wire fwl_pkg::fwl_pins_t pinsIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic quadMode,
  input wire logic softReset,
  input wire logic addrLenNv,
  input wire logic embeddedBusy,
  input wire logic programErrSet,
  input wire logic eraseErrSet,
  input wire logic regWriteDone,
  input wire logic patternProgramFail,
  output fwl_pkg::fwl_status_t status,
  output logic writeGateOpen,
  output logic [7:0] patternVol,
  output logic [7:0] patternNv
);
  import fwl_pkg::*;

  // Synchronised pins; the link clock is sampled like any other pin
  fwl_pins_t pinsSync;
  logic [$bits(fwl_pins_t)-1:0] syncRaw; // Synchroniser out, idle as zero
  logic sckPrev_ff; // Last sampled link clock
  logic csPrev_ff; // Last sampled select
  logic sckRise; // Host samples-in edge
  logic sckFall; // Device drive edge
  logic csRise; // End of frame

  // Decoder state
  fwl_state_t state_ff;
  fwl_state_t nxt_state;
  logic [7:0] rxShift_ff; // Incoming bits, newest in LSB
  logic [7:0] nxt_rxShift;
  logic [5:0] bitCnt_ff; // Bits taken this frame
  logic [5:0] nxt_bitCnt;
  logic [7:0] opcode_ff; // Instruction byte of this frame
  logic [7:0] dataByte_ff; // Data byte of this frame
  logic [2:0] outIdx_ff; // Bit or nibble position of the read byte

  // Status flags
  logic wel_ff; // Write permit latch
  logic steer_ff; // Next register write goes to volatile copies
  logic wip_ff; // Self-timed pattern program running
  logic pErr_ff; // Program error
  logic eErr_ff; // Erase error
  logic ads_ff; // Address length bit
  logic strapDone_ff; // Address length loaded after release
  logic [11:0] progCnt_ff; // Program time left
  logic [7:0] progData_ff; // Byte being programmed
  logic [7:0] patVol_ff; // Volatile learning pattern
  logic [7:0] patNv_ff; // Non-volatile learning pattern
  logic [3:0] ioOut_ff; // Drive value on IO lines
  logic [3:0] ioOe_ff; // Drive enable on IO lines

  // Command execution pulses, decoded at frame end
  logic execute;
  logic doPermit;
  logic doForbid;
  logic doSteer;
  logic doClear;
  logic doNvProgram;
  logic doVolWrite;
  logic doEnterWide;
  logic doExitWide;
  logic progDone;
  logic inProgress;
  logic [5:0] step;

  // Bring csN, sck and io into the clock domain together, so data
  // and clock edges keep their relative order
  fwl_sync #(
    .WIDTH($bits(fwl_pins_t))
  ) uSync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn(pinsIn ^ PINS_IDLE),
    .syncOut(syncRaw)
  );

  // Synchroniser clears to zero; folding keeps select high after
  // reset, so no false frame start or select edge follows release
  assign pinsSync = syncRaw ^ PINS_IDLE;

  // Previous samples for edge detection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_ff <= 1'b0;
      csPrev_ff <= 1'b1;
    end else begin
      sckPrev_ff <= pinsSync.sck;
      csPrev_ff <= pinsSync.csN;
    end
  end

  // Link edges; only meaningful while selected
  assign sckRise = pinsSync.sck & ~sckPrev_ff & ~pinsSync.csN;
  assign sckFall = ~pinsSync.sck & sckPrev_ff & ~pinsSync.csN;
  assign csRise = pinsSync.csN & ~csPrev_ff;

  // One bit per clock normally, four in quad mode
  assign step = quadMode ? STEP_QUAD : STEP_SINGLE; // [R20]

  // Shift and count the incoming bits
  always_comb begin
    if (quadMode) begin
      nxt_rxShift = {rxShift_ff[3:0], pinsSync.io}; // [R20]
    end else begin
      nxt_rxShift = {rxShift_ff[6:0], pinsSync.io[0]};
    end
    if (bitCnt_ff > (6'h3F - step)) begin
      nxt_bitCnt = bitCnt_ff; // Saturate on long frames
    end else begin
      nxt_bitCnt = bitCnt_ff + step;
    end
  end

  // Frame decoder: opcode, data byte, dummy, read-out
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!pinsSync.csN) begin
          nxt_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (sckRise && nxt_bitCnt == OPCODE_BITS) begin
          if (nxt_rxShift == OP_PATTERN_READ) begin
            nxt_state = ST_DUMMY; // [R15]
          end else if (nxt_rxShift == OP_PATTERN_NV_PROGRAM ||
                       nxt_rxShift == OP_PATTERN_VOL_WRITE) begin
            nxt_state = ST_DATA; // [R11] [R13]
          end else if (nxt_rxShift == OP_WRITE_PERMIT ||
                       nxt_rxShift == OP_WRITE_FORBID ||
                       nxt_rxShift == OP_VOLATILE_STEER ||
                       nxt_rxShift == OP_STATUS_CLEAR ||
                       nxt_rxShift == OP_ENTER_WIDE_ADDR ||
                       nxt_rxShift == OP_EXIT_WIDE_ADDR) begin
            nxt_state = ST_TAIL;
          end else begin
            nxt_state = ST_SKIP; // Not ours
          end
        end
      end
      ST_DATA: begin
        if (sckRise && nxt_bitCnt == DATA_END_BITS) begin
          nxt_state = ST_TAIL;
        end
      end
      ST_TAIL: begin
        // Any further rising clock edge spoils the command
        if (sckRise) begin
          nxt_state = ST_SKIP; // [R03] [R11] [R13]
        end
      end
      ST_DUMMY: begin
        // IO lines carry nothing of use here
        if (sckRise) begin
          nxt_state = ST_READ; // [R16]
        end
      end
      ST_READ: begin
        nxt_state = ST_READ;
      end
      ST_SKIP: begin
        nxt_state = ST_SKIP;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Deselect always ends the frame
    if (pinsSync.csN) begin
      nxt_state = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Receive path; bits taken on link rising edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxShift_ff <= 8'h00;
      bitCnt_ff <= 6'h00;
      opcode_ff <= 8'h00;
      dataByte_ff <= 8'h00;
    end else if (pinsSync.csN) begin
      // Fresh count for the next frame
      bitCnt_ff <= 6'h00;
    end else if (sckRise && state_ff != ST_DUMMY) begin
      rxShift_ff <= nxt_rxShift;
      bitCnt_ff <= nxt_bitCnt;
      if (state_ff == ST_CMD && nxt_bitCnt == OPCODE_BITS) begin
        opcode_ff <= nxt_rxShift;
      end
      if (state_ff == ST_DATA && nxt_bitCnt == DATA_END_BITS) begin
        dataByte_ff <= nxt_rxShift;
      end
    end
  end

  // A command runs only when select rises right after its last bit
  assign execute = csRise & (state_ff == ST_TAIL); // [R03]
  assign doPermit = execute & (opcode_ff == OP_WRITE_PERMIT);
  assign doForbid = execute & (opcode_ff == OP_WRITE_FORBID) &
                    ~inProgress; // [R05]
  assign doSteer = execute & (opcode_ff == OP_VOLATILE_STEER);
  // No permit and no idle state needed for a status clear
  assign doClear = execute & (opcode_ff == OP_STATUS_CLEAR); // [R09]
  // Program refused without the latch or while anything runs
  assign doNvProgram = execute & (opcode_ff == OP_PATTERN_NV_PROGRAM) &
                       wel_ff & ~inProgress; // [R02] [R06] [R11]
  assign doVolWrite = execute & (opcode_ff == OP_PATTERN_VOL_WRITE) &
                      wel_ff; // [R02] [R13]
  assign doEnterWide = execute & (opcode_ff == OP_ENTER_WIDE_ADDR);
  assign doExitWide = execute & (opcode_ff == OP_EXIT_WIDE_ADDR);
  assign progDone = wip_ff & (progCnt_ff == 12'h001);

  // Busy covers own program, other embedded work and error hang
  assign inProgress = wip_ff | embeddedBusy | pErr_ff | eErr_ff; // [R10]

  // Write permit latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wel_ff <= 1'b0;
    end else if (doPermit) begin
      wel_ff <= 1'b1; // [R01]
    end else if (doForbid || doClear) begin
      wel_ff <= 1'b0; // [R04] [R08]
    end else if (progDone || regWriteDone) begin
      // Completed write operations give up the permit
      wel_ff <= 1'b0; // [R12]
    end
  end

  // Register write target; steer leaves the latch alone
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      steer_ff <= 1'b0;
    end else if (doSteer) begin
      steer_ff <= 1'b1; // [R07] [R21]
    end else if (doPermit || regWriteDone) begin
      steer_ff <= 1'b0; // [R21]
    end
  end

  // Self-timed pattern program; status clear aborts it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wip_ff <= 1'b0;
      progCnt_ff <= 12'h000;
      progData_ff <= 8'h00;
    end else if (doNvProgram) begin
      wip_ff <= 1'b1; // [R12]
      progCnt_ff <= PROG_CYCLES;
      progData_ff <= dataByte_ff;
    end else if (doClear) begin
      wip_ff <= 1'b0; // [R08]
      progCnt_ff <= 12'h000;
    end else if (wip_ff) begin
      progCnt_ff <= progCnt_ff - 12'h001;
      if (progDone) begin
        wip_ff <= 1'b0; // [R12]
      end
    end
  end

  // Error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pErr_ff <= 1'b0;
      eErr_ff <= 1'b0;
    end else begin
      pErr_ff <= programErrSet | (progDone & patternProgramFail) |
                 (pErr_ff & ~doClear); // [R08] [R12]
      eErr_ff <= eraseErrSet | (eErr_ff & ~doClear); // [R08]
    end
  end

  // Pattern registers; failed programs leave the old value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      patNv_ff <= PATTERN_NV_RST;
      patVol_ff <= PATTERN_VOL_RST;
    end else begin
      if (progDone && !patternProgramFail) begin
        patNv_ff <= progData_ff; // [R12]
      end
      if (doVolWrite) begin
        patVol_ff <= dataByte_ff; // [R13]
      end else if (!strapDone_ff || softReset) begin
        patVol_ff <= patNv_ff; // [R22]
      end
    end
  end

  // Address length; loaded from the strap after every reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ads_ff <= 1'b0;
      strapDone_ff <= 1'b0;
    end else begin
      strapDone_ff <= 1'b1;
      if (!strapDone_ff || softReset) begin
        ads_ff <= addrLenNv; // [R19]
      end else if (doEnterWide) begin
        ads_ff <= 1'b1; // [R17]
      end else if (doExitWide) begin
        ads_ff <= 1'b0; // [R18]
      end
    end
  end

  // Read-out on link falling edges; the byte repeats endlessly
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ioOut_ff <= 4'h0;
      ioOe_ff <= 4'h0;
      outIdx_ff <= 3'h0;
    end else if (state_ff != ST_READ || pinsSync.csN) begin
      // Release the lines outside the read phase
      ioOe_ff <= 4'h0;
      outIdx_ff <= 3'h0;
    end else if (sckFall) begin
      if (quadMode) begin
        ioOe_ff <= 4'hF; // [R20]
        ioOut_ff <= outIdx_ff[0] ? patVol_ff[3:0] :
                    patVol_ff[7:4]; // [R15] [R22]
        outIdx_ff <= {2'b00, ~outIdx_ff[0]};
      end else begin
        // Serial output line only, MSB first
        ioOe_ff <= 4'h2;
        ioOut_ff <= {2'b00, patVol_ff[3'h7 - outIdx_ff], 1'b0}; // [R15]
        outIdx_ff <= outIdx_ff + 3'h1;
      end
    end
  end

  // Outputs
  assign ioOut = ioOut_ff;
  assign ioOe = ioOe_ff;
  assign status.inProgress = inProgress;
  assign status.writePermit = wel_ff;
  assign status.programErr = pErr_ff;
  assign status.eraseErr = eErr_ff;
  assign status.addressLength = ads_ff;
  assign status.steerVolatile = steer_ff;
  // Other write, program and erase commands look here first
  assign writeGateOpen = wel_ff; // [R06]
  assign patternVol = patVol_ff;
  assign patternNv = patNv_ff;

endmodule : fwl_cmd

// ==== verif/fwl_cmd_sva.sv ====
// Assertion checker for the write latch and mode command logic
`timescale 1ns/1ps
module fwl_cmd_sva (
  input wire logic clock,
  input wire logic arst_n,
  input wire fwl_pkg::fwl_pins_t pinsIn,
  input wire logic [3:0] ioOe,
  input wire logic softReset,
  input wire logic addrLenNv,
  input wire logic embeddedBusy,
  input wire fwl_pkg::fwl_status_t status,
  input wire logic writeGateOpen,
  input wire logic [7:0] patternNv
);
  import fwl_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Busy rising with no outside cause: self-timed program
  sequence progStart;
    $rose(status.inProgress) && !embeddedBusy && !status.programErr &&
      !status.eraseErr;
  endsequence
  // Busy must not drop straight away
  sequence progHold;
    status.inProgress [*8];
  endsequence
  a_gate_follows: assert property (
    writeGateOpen == status.writePermit) else $error("gate differs");
  a_err_busy: assert property (
    status.programErr || status.eraseErr |-> status.inProgress)
    else $error("error flag without busy");
  a_oe_codes: assert property (
    ioOe inside {4'h0, 4'h2, 4'hF}) else $error("bad enable mix");
  a_oe_release: assert property (
    pinsIn.csN [*5] |-> ioOe == 4'h0) else $error("driving deselected");
  a_permit_rise: assert property (
    $rose(status.writePermit) |-> $past(pinsIn.csN))
    else $error("latch set inside a frame");
  a_steer_latch: assert property (
    $rose(status.steerVolatile) |-> $stable(status.writePermit))
    else $error("steer moved the latch");
  a_nv_done: assert property (
    $changed(patternNv) |-> !status.writePermit)
    else $error("latch left set after program");
  a_prog_hold: assert property (
    progStart |=> progHold) else $error("program busy too short");
  a_addr_reload: assert property (
    softReset |=> status.addressLength == $past(addrLenNv))
    else $error("address length not reloaded");
endmodule : fwl_cmd_sva

bind fwl_cmd fwl_cmd_sva u_sva (.clock, .arst_n, .pinsIn, .ioOe,
  .softReset, .addrLenNv, .embeddedBusy, .status, .writeGateOpen,
  .patternNv);

// ==== verif/fwl_host.sv ====
// Host model driving the serial link pins
`timescale 1ns/1ps
module fwl_host (
  output fwl_pkg::fwl_pins_t pins,
  input wire logic [3:0] ioOut,
  input wire logic quadMode
);
  import fwl_pkg::*;
  localparam int HALF = 80; // Far below the link limit
  // Deselected, link clock low, lines toggling
  initial pins = '{csN: 1'b1, sck: 1'b0, io: 4'hA};
  // One link clock: present unit, rise and sample, fall
  task automatic pulse(input logic [3:0] v, output logic [3:0] s);
    pins.io = v;
    #HALF pins.sck = 1'b1;
    s = ioOut;
    #HALF pins.sck = 1'b0;
  endtask : pulse
  // Frame: opcode, nd data bytes, dummy plus nr read bytes, ex extras
  task automatic frame(input logic [7:0] op, input int nd,
      input logic [7:0] d, input int nr, input int ex,
      output logic [7:0] rd);
    logic [3:0] s;
    logic [15:0] sh;
    int step;
    step = quadMode ? 4 : 1; // Nibbles, high first
    sh = {op, d};
    rd = 8'h00;
    pins.csN = 1'b0;
    for (int i = 0; i < 8 * (nd + 1); i += step) begin
      // Unused lines keep moving so no stale level is read
      pulse(step == 4 ? sh[15:12] : {~pins.io[3:1], sh[15]}, s);
      sh = sh << step;
    end
    if (nr > 0) begin
      pulse(~pins.io, s); // Dummy: junk on the lines
      for (int j = 0; j < 8 * nr; j += step) begin
        pulse(~pins.io, s);
        rd = step == 4 ? {rd[3:0], s} : {rd[6:0], s[1]};
      end
    end
    for (int k = 0; k < ex; k++) begin
      pulse(~pins.io, s);
    end
    #HALF pins.csN = 1'b1; // Right after the last unit
    pins.io = ~pins.io;
    #300;
  endtask : frame
endmodule : fwl_host

// ==== verif/tb_top.sv ====
// Self-checking bench of the write latch and mode command logic
`timescale 1ns/1ps
module tb_top;
  import fwl_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic quadMode = 1'b0, softReset = 1'b0, addrLenNv = 1'b0;
  logic embeddedBusy = 1'b0, programErrSet = 1'b0, eraseErrSet = 1'b0;
  logic regWriteDone = 1'b0, patternProgramFail = 1'b0;
  fwl_pins_t pins;
  logic [3:0] ioOut, ioOe;
  fwl_status_t status;
  logic writeGateOpen;
  logic [7:0] patternVol, patternNv;
  // Reference state of the device
  int write_permit_latch = 0, steer = 0, address_length_bit = 0, in_progress_bit = 0, perr = 0, eerr = 0;
  int patV = 0, patNv = 0, nvD = 0;
  int bad_count = 0, check_count = 0;

  always #5 clock = ~clock;

  fwl_host u_host (.pins(pins), .ioOut(ioOut), .quadMode(quadMode));
  fwl_cmd u_dut (.clock(clock), .arst_n(arst_n), .pinsIn(pins),
    .ioOut(ioOut), .ioOe(ioOe), .quadMode(quadMode),
    .softReset(softReset), .addrLenNv(addrLenNv),
    .embeddedBusy(embeddedBusy), .programErrSet(programErrSet),
    .eraseErrSet(eraseErrSet), .regWriteDone(regWriteDone),
    .patternProgramFail(patternProgramFail), .status(status),
    .writeGateOpen(writeGateOpen), .patternVol(patternVol),
    .patternNv(patternNv));

  // Verdict and end of run
  task automatic wrap_up;
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Inputs move just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic hit(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask : hit
  task automatic cmp;
    logic [5:0] e;
    e = {steer[0], address_length_bit[0], eerr[0], perr[0], write_permit_latch[0],
      (in_progress_bit | perr | eerr | embeddedBusy) != 0};
    chk(32'(status), 32'(e));
    chk(32'(patternVol), patV);
    chk(32'(patternNv), patNv);
    chk(32'(writeGateOpen), write_permit_latch);
  endtask : cmp
  // One command frame, then the reference moves on
  task automatic run(input logic [7:0] c, input int nd, input int ex);
    logic [7:0] d, r;
    int bz;
    // Fresh byte each time; a failed program must keep the old one
    d = 8'($urandom);
    bz = in_progress_bit | perr | eerr | int'(embeddedBusy);
    u_host.frame(c, nd, d, 0, ex, r);
    tick(1);
    if (ex == 0 && nd == int'(c == OP_PATTERN_NV_PROGRAM ||
        c == OP_PATTERN_VOL_WRITE)) begin
      case (c)
        OP_WRITE_PERMIT: begin
          write_permit_latch = 1;
          steer = 0;
        end
        OP_VOLATILE_STEER: steer = 1;
        OP_WRITE_FORBID: if (bz == 0) write_permit_latch = 0;
        OP_STATUS_CLEAR: begin
          write_permit_latch = 0;
          in_progress_bit = 0;
          perr = 0;
          eerr = 0;
        end
        OP_PATTERN_VOL_WRITE: if (write_permit_latch != 0) patV = d;
        OP_PATTERN_NV_PROGRAM: if (write_permit_latch != 0 && bz == 0) begin
          in_progress_bit = 1;
          nvD = d;
        end
        OP_ENTER_WIDE_ADDR: address_length_bit = 1;
        OP_EXIT_WIDE_ADDR: address_length_bit = 0;
        default: ;
      endcase
    end
    cmp;
  endtask : run
  task automatic rd(input int nr);
    logic [7:0] r;
    u_host.frame(OP_PATTERN_READ, 0, 8'h00, nr, 0, r);
    tick(1);
    chk(32'(r), patV);
  endtask : rd
  // Self-timed program, waited for under a bound
  task automatic nv_prog(input logic fail);
    int n;
    n = 0;
    patternProgramFail = fail;
    run(OP_WRITE_PERMIT, 0, 0);
    run(OP_PATTERN_NV_PROGRAM, 1, 0);
    while (status.inProgress === 1'b1 && status.programErr !== 1'b1) begin
      tick(1);
      n++;
      if (n > 3000) begin
        bad_count++;
        wrap_up;
      end
    end
    tick(2);
    in_progress_bit = 0;
    write_permit_latch = 0;
    perr = int'(fail);
    if (!fail) patNv = nvD;
    patternProgramFail = 1'b0;
    cmp;
  endtask : nv_prog

  initial begin
    void'($urandom(41434));
    tick(8);
    arst_n = 1'b1;
    tick(6);
    cmp;
    for (int q = 0; q < 2; q++) begin
      quadMode = q[0];
      run(OP_PATTERN_VOL_WRITE, 1, 0);
      run(OP_WRITE_PERMIT, 0, 2);
      run(OP_WRITE_PERMIT, 0, 0);
      run(OP_VOLATILE_STEER, 0, 0);
      run(OP_PATTERN_VOL_WRITE, 1, 0);
      rd(2);
      run(OP_ENTER_WIDE_ADDR, 0, 0);
      run(OP_EXIT_WIDE_ADDR, 0, 0);
      run(OP_ENTER_WIDE_ADDR, 0, 0);
      run(OP_WRITE_FORBID, 0, 0);
      run(OP_STATUS_CLEAR, 0, 0);
    end
    run(OP_WRITE_PERMIT, 0, 0);
    run(OP_VOLATILE_STEER, 0, 0);
    hit(regWriteDone);
    write_permit_latch = 0;
    steer = 0;
    cmp;
    run(OP_WRITE_PERMIT, 0, 0);
    hit(programErrSet);
    perr = 1;
    cmp;
    run(OP_WRITE_FORBID, 0, 0);
    run(OP_STATUS_CLEAR, 0, 0);
    hit(eraseErrSet);
    eerr = 1;
    run(OP_STATUS_CLEAR, 0, 0);
    run(OP_WRITE_PERMIT, 0, 0);
    embeddedBusy = 1'b1;
    run(OP_WRITE_FORBID, 0, 0);
    embeddedBusy = 1'b0;
    run(OP_STATUS_CLEAR, 0, 0);
    nv_prog(1'b0);
    rd(1);
    nv_prog(1'b1);
    run(OP_STATUS_CLEAR, 0, 0);
    addrLenNv = 1'b1;
    hit(softReset);
    address_length_bit = 1;
    patV = patNv;
    cmp;
    addrLenNv = 1'b0;
    run(OP_ENTER_WIDE_ADDR, 0, 0);
    hit(softReset);
    address_length_bit = 0;
    cmp;
    rd(1);
    wrap_up;
  end
endmodule : tb_top
